/* File: src/adc_ctrl_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define OFS_INPUT_CFG 12'h000
`define OFS_MODE_CFG 12'h004
`define OFS_SEQ_EN 12'h008
`define OFS_CAL_CTRL 12'h00c
`define OFS_OSC_CFG 12'h010
`define OFS_CONV_CLKS 12'h014
`define OFS_SEQ_STATUS 12'h018
`define OFS_OFFSET_VAL 12'h01c
`define OFS_RESULT 12'h020
`define OFS_IRQ_STATUS 12'h024
`define OFS_IRQ_CLEAR 12'h028
`define OFS_IRQ_ENABLE 12'h02c
`define RST_INPUT_CFG 2'h0
`define RST_MODE_CFG 3'h0
`define RST_SEQ_EN 2'h1
`define RST_OSCILLATOR_CHOICE 1'h0
`define RST_CONV_CLKS 16'h0020
`define CAL_CYCLES 16'h0040
`define HS_DIV 8'h01
`define LP_DIV 8'h20
`define MID_CODE 12'h800
`define IRQ_CONV_BIT 0
`define IRQ_CAL_BIT 1
`define IRQ_ERR_BIT 2
`endif

/* File: src/adc_ctrl_pkg.sv */
// Types shared by the converter control block
package adc_ctrl_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CAL = 4'b0010,
      ST_SAMPLE = 4'b0100,
      ST_CONVERT = 4'b1000
   } conv_state_t;
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'h0,
      MODE_MANUAL_SEQ = 2'h1,
      MODE_AUTONOMOUS = 2'h2,
      MODE_PRECISION = 2'h3
   } op_mode_t;
   typedef struct packed {
      logic firstCapSelect;
      logic secondCapGround;
      logic secondCapNegative;
      logic switchesClosed;
   } mux_ctrl_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
endpackage : adc_ctrl_pkg

/* File: src/adc_input_config_and_timing.sv */
// Converter front-end control: input arrangement, sequencing, calibration, timing
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_input_config_and_timing
   import adc_ctrl_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clock, // System clock, 250 MHz
   input wire logic sys_rst, // Async reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [11:0] sarCode, // Raw converter code
   output logic firstCapSelect, // 0 positive pin, 1 negative pin
   output logic secondCapGround, // Second capacitor on ground
   output logic secondCapNegative, // Second capacitor on negative pin
   output logic samplingSwitchesClosed, // Acquisition switches closed
   output logic busy, // Busy indication pin
   output logic lowPowerOscEnable, // Low-power oscillator in use
   output logic irq // Level interrupt
);
   initial begin
      if (CNT_W < 8 || CNT_W > 32) $error("CNT_W out of range");
   end

   apb_req_t req;
   assign req = '{psel, penable, pwrite, paddr, pwdata};

   logic [1:0] inputArrangementSelect;
   logic [2:0] operatingModeSelect;
   logic [1:0] sequenceChannelEnables;
   logic oscillatorChoice;
   logic [CNT_W-1:0] conversionClockCount;
   logic [11:0] offsetCorrection;
   logic [11:0] result;
   logic [2:0] irqStatus;
   logic [2:0] irqEnable;
   logic sequenceError;
   logic calPending;
   logic [15:0] calCount;
   logic currentChannel;
   conv_state_t state;
   conv_state_t next_state;
   mux_ctrl_t mux;

   // Bus decode
   wire access = req.psel && req.penable;
   wire wrEn = access && req.pwrite;
   wire hitInput = req.paddr == `OFS_INPUT_CFG;
   wire hitMode = req.paddr == `OFS_MODE_CFG;
   wire hitSeq = req.paddr == `OFS_SEQ_EN;
   wire hitCal = req.paddr == `OFS_CAL_CTRL;
   wire hitOsc = req.paddr == `OFS_OSC_CFG;
   wire hitClks = req.paddr == `OFS_CONV_CLKS;
   wire hitSeqSt = req.paddr == `OFS_SEQ_STATUS;
   wire hitOffs = req.paddr == `OFS_OFFSET_VAL;
   wire hitRes = req.paddr == `OFS_RESULT;
   wire hitIrqSt = req.paddr == `OFS_IRQ_STATUS;
   wire hitIrqClr = req.paddr == `OFS_IRQ_CLEAR;
   wire hitIrqEn = req.paddr == `OFS_IRQ_ENABLE;
   wire mapped = hitInput | hitMode | hitSeq | hitCal | hitOsc | hitClks | hitSeqSt
      | hitOffs | hitRes | hitIrqSt | hitIrqClr | hitIrqEn;
   wire calTrigger = wrEn && hitCal && req.pwdata[0];

   // Mode decode
   wire singleInput = (inputArrangementSelect == 2'b01) || (inputArrangementSelect == 2'b10);
   // Reserved codes 010 and 011 fall back to manual
   wire seqMode = operatingModeSelect[2];
   op_mode_t opMode;
   assign opMode = !seqMode ? MODE_MANUAL :
      (operatingModeSelect[1:0] == 2'b10) ? MODE_AUTONOMOUS :
      (operatingModeSelect[1:0] == 2'b11) ? MODE_PRECISION : MODE_MANUAL_SEQ;
   wire [1:0] activeChannels = seqMode ? sequenceChannelEnables : 2'b01;
   wire ch1Illegal = singleInput && sequenceChannelEnables[1];

   // Next channel in sequence order; single-input arrangements never convert channel 1
   wire secondActive = activeChannels[1] && !singleInput;
   wire nextChannel = (currentChannel == 1'b0 && secondActive) ? 1'b1
      : 1'b0;
   wire firstChannel = activeChannels[0] ? 1'b0 : (singleInput ? 1'b0 : 1'b1);
   wire anyChannel = activeChannels[0] || secondActive;

   // Conversion timing
   logic convTick;
   logic oscTick;
   wire [7:0] oscDivide = oscillatorChoice ? `LP_DIV : `HS_DIV;
   wire runConv = (state != ST_CAL) && anyChannel;
   conv_tick_divider #(
      .WIDTH(CNT_W)
   ) divider (
      .clock(clock),
      .sys_rst(sys_rst),
      .oscDivide(oscDivide),
      .clocksPerConv(conversionClockCount),
      .run(runConv),
      .oscTick(oscTick),
      .convTick(convTick)
   );

   // Offset-corrected straight binary, clamped to both full-scale codes
   wire [13:0] corrected = {2'b00, sarCode} - {2'b00, offsetCorrection} + {2'b00, `MID_CODE};
   wire belowScale = corrected[13];
   wire aboveScale = !corrected[13] && corrected[12];
   wire [11:0] sarSat = belowScale ? 12'h000 : aboveScale ? 12'hfff : corrected[11:0];

   // Mux control per arrangement
   always_comb begin
      mux.switchesClosed = (state == ST_SAMPLE);
      if (singleInput) begin
         mux.firstCapSelect = 1'b0;
         mux.secondCapGround = 1'b0;
         mux.secondCapNegative = 1'b1;
      end else begin
         mux.firstCapSelect = currentChannel;
         mux.secondCapGround = 1'b1;
         mux.secondCapNegative = 1'b0;
      end
   end

   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (calPending) next_state = ST_CAL;
            else if (convTick) next_state = ST_SAMPLE;
         end
         ST_CAL: begin
            if (calCount == `CAL_CYCLES) next_state = ST_IDLE;
         end
         ST_SAMPLE: begin
            if (oscTick) next_state = ST_CONVERT;
         end
         ST_CONVERT: begin
            if (oscTick) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) state <= ST_IDLE;
      else state <= next_state;
   end

   // Calibration: starts on reset, re-armed by trigger
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         calPending <= 1'b1;
         calCount <= 16'h0000;
         offsetCorrection <= 12'h800;
      end else begin
         if (calTrigger) calPending <= 1'b1;
         else if (state == ST_CAL) calPending <= 1'b0;
         if (state == ST_CAL) calCount <= calCount + 16'h0001;
         else calCount <= 16'h0000;
         if (state == ST_CAL && calCount == `CAL_CYCLES) begin
            offsetCorrection <= sarCode;
         end
      end
   end

   // Channel stepping and result capture
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         currentChannel <= 1'b0;
         result <= 12'h000;
      end else if (state == ST_CONVERT && oscTick) begin
         result <= sarSat;
         currentChannel <= nextChannel ? 1'b1 : firstChannel;
      end else if (state == ST_IDLE && currentChannel && !secondActive) begin
         currentChannel <= firstChannel;
      end
   end

   // Configuration registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         inputArrangementSelect <= `RST_INPUT_CFG;
         operatingModeSelect <= `RST_MODE_CFG;
         sequenceChannelEnables <= `RST_SEQ_EN;
         oscillatorChoice <= `RST_OSCILLATOR_CHOICE;
         conversionClockCount <= CNT_W'(`RST_CONV_CLKS);
         irqEnable <= 3'h0;
      end else if (wrEn) begin
         if (hitInput) inputArrangementSelect <= req.pwdata[1:0];
         if (hitMode) operatingModeSelect <= req.pwdata[2:0];
         if (hitSeq) sequenceChannelEnables <= req.pwdata[1:0];
         if (hitOsc) oscillatorChoice <= req.pwdata[0];
         if (hitClks) conversionClockCount <= req.pwdata[CNT_W-1:0];
         if (hitIrqEn) irqEnable <= req.pwdata[2:0];
      end
   end

   // Sticky events, set wins over clear
   wire convDone = (state == ST_CONVERT) && oscTick;
   wire calDone = (state == ST_CAL) && (calCount == `CAL_CYCLES);
   wire errRise = ch1Illegal && !sequenceError;
   wire [2:0] events = {errRise, calDone, convDone};
   wire [2:0] clearMask = (wrEn && hitIrqClr) ? req.pwdata[2:0] : 3'h0;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irqStatus <= 3'h0;
         sequenceError <= 1'b0;
      end else begin
         irqStatus <= (irqStatus & ~clearMask) | events;
         sequenceError <= ch1Illegal;
      end
   end

   // Read mux
   logic [31:0] readData;
   always_comb begin
      readData = 32'h0000_0000;
      if (hitInput) readData[1:0] = inputArrangementSelect;
      if (hitMode) readData[2:0] = operatingModeSelect;
      if (hitSeq) readData[1:0] = sequenceChannelEnables;
      if (hitCal) readData[0] = calPending || (state == ST_CAL);
      if (hitOsc) readData[0] = oscillatorChoice;
      if (hitClks) readData[CNT_W-1:0] = conversionClockCount;
      if (hitSeqSt) readData[2:0] = {currentChannel, state == ST_CAL, sequenceError};
      if (hitSeqSt) readData[5:4] = opMode;
      if (hitOffs) readData[11:0] = offsetCorrection;
      if (hitRes) readData[11:0] = result;
      if (hitIrqSt) readData[2:0] = irqStatus;
      if (hitIrqEn) readData[2:0] = irqEnable;
   end

   // Next values of the registered pins
   wire setupPhase = req.psel && !req.penable;
   wire next_pready = setupPhase;
   wire next_pslverr = setupPhase && !mapped;
   wire [31:0] next_prdata = (setupPhase && !req.pwrite) ? readData : 32'h0000_0000;
   // Busy only while calibrating, so calibration never overlaps a closed switch
   wire next_busy = (next_state == ST_CAL);
   wire next_switches = mux.switchesClosed && (next_state != ST_CAL);
   wire next_irq = |(((irqStatus & ~clearMask) | events) & irqEnable);

   // APB answer in the first access cycle
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // Input switching pins
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         firstCapSelect <= 1'b0;
         secondCapGround <= 1'b1;
         secondCapNegative <= 1'b0;
         samplingSwitchesClosed <= 1'b0;
      end else begin
         firstCapSelect <= mux.firstCapSelect;
         secondCapGround <= mux.secondCapGround;
         secondCapNegative <= mux.secondCapNegative;
         samplingSwitchesClosed <= next_switches;
      end
   end

   // Status pins
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         busy <= 1'b1;
         lowPowerOscEnable <= 1'b0;
         irq <= 1'b0;
      end else begin
         busy <= next_busy;
         lowPowerOscEnable <= oscillatorChoice;
         irq <= next_irq;
      end
   end
endmodule : adc_input_config_and_timing
`default_nettype wire

/* File: src/conv_tick_divider.sv */
// Conversion-clock tick generator from the chosen oscillator
`timescale 1ns/1ns
`default_nettype none
module conv_tick_divider #(
   parameter int WIDTH = 16
) (
   input wire logic clock, // System clock
   input wire logic sys_rst, // Async reset
   input wire logic [7:0] oscDivide, // Clocks per oscillator tick
   input wire logic [WIDTH-1:0] clocksPerConv, // Oscillator ticks per conversion
   input wire logic run, // Counting enabled
   output logic oscTick, // One oscillator tick
   output logic convTick // Start of a conversion cycle
);
   initial begin
      if (WIDTH < 2) $error("WIDTH too small");
   end
   logic [7:0] preCount;
   logic [WIDTH-1:0] tickCount;
   wire preWrap = (preCount + 8'h01 >= oscDivide);
   wire [WIDTH-1:0] lastTick = (clocksPerConv == '0) ? '0 : clocksPerConv - 1'b1;
   wire convWrap = preWrap && (tickCount >= lastTick);
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         preCount <= 8'h00;
         tickCount <= '0;
         oscTick <= 1'b0;
         convTick <= 1'b0;
      end else begin
         oscTick <= run && preWrap;
         convTick <= run && convWrap;
         preCount <= (!run || preWrap) ? 8'h00 : preCount + 8'h01;
         if (!run || convWrap) tickCount <= '0;
         else if (preWrap) tickCount <= tickCount + 1'b1;
      end
   end
endmodule : conv_tick_divider
`default_nettype wire

/* File: verification/adc_ctrl_properties.sv */
// Port assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_ctrl_properties (
   input wire logic clock, // Clock
   input wire logic sys_rst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic secondCapGround, // Cap on ground
   input wire logic secondCapNegative, // Cap on negative pin
   input wire logic samplingSwitchesClosed, // Acquisition
   input wire logic busy, // Busy pin
   input wire logic lowPowerOscEnable // Oscillator
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_osc_wr;
      psel && penable && pready && pwrite && paddr == `OFS_OSC_CFG;
   endsequence
   property p_answer;
      s_setup |=> pready;
   endproperty
   property p_pulse;
      pready |=> !pready;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_idle_zero;
      !pready |-> prdata == 32'h0;
   endproperty
   property p_caps;
      secondCapGround != secondCapNegative;
   endproperty
   property p_cal_open;
      busy |-> !samplingSwitchesClosed;
   endproperty
   property p_boot_cal;
      $past(sys_rst) |-> busy;
   endproperty
   property p_osc;
      s_osc_wr |=> ##1 lowPowerOscEnable == $past(pwdata[0], 2);
   endproperty
   property p_result;
      pready && !pwrite && paddr == `OFS_RESULT |-> prdata[31:12] == 20'h0;
   endproperty
   a_answer: assert property (p_answer) else $error("no ready after setup");
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("error without ready");
   a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");
   a_caps: assert property (p_caps) else $error("second cap routing");
   a_cal_open: assert property (p_cal_open) else $error("switches closed while busy");
   a_boot_cal: assert property (p_boot_cal) else $error("no calibration at start");
   a_osc: assert property (p_osc) else $error("oscillator choice not applied");
   a_result: assert property (p_result) else $error("result wider than 12 bits");
endmodule : adc_ctrl_properties
bind adc_input_config_and_timing adc_ctrl_properties chk (.clock, .sys_rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .secondCapGround,
   .secondCapNegative, .samplingSwitchesClosed, .busy, .lowPowerOscEnable);
`default_nettype wire

/* File: verification/sensor_model.sv */
// Sensor front end feeding held converter codes
`timescale 1ns/1ns
`default_nettype none
module sensor_model (
   input wire logic clock, // Clock
   input wire logic firstCapSelect, // Channel on first cap
   input wire logic samplingSwitchesClosed, // Acquisition
   input wire logic busy, // Calibration running
   input wire logic [11:0] level0, // Channel 0 code
   input wire logic [11:0] level1, // Channel 1 code
   input wire logic [11:0] calLevel, // Code with inputs open
   output logic [11:0] sarCode // Held sample
);
   always_ff @(posedge clock) begin
      if (busy) begin
         sarCode <= calLevel;
      end else if (samplingSwitchesClosed) begin
         sarCode <= firstCapSelect ? level1 : level0;
      end
   end
endmodule : sensor_model
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_map.svh"
module tb;
   import adc_ctrl_pkg::*;
   logic clock = 0;
   logic sys_rst = 1;
   apb_req_t req = '0;
   logic [31:0] prdata;
   logic pready, pslverr, firstCapSelect, secondCapGround, secondCapNegative;
   logic samplingSwitchesClosed, busy, lowPowerOscEnable, irq;
   logic [11:0] sarCode;
   logic [11:0] level0 = 12'h800;
   logic [11:0] level1 = 12'h400;
   logic [11:0] calLevel = 12'h805;
   logic [32:0] expQ[$];
   logic [32:0] note;
   logic [15:0] lfsr = 16'h26d7; // Seed 9943
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   int t0;
   adc_input_config_and_timing uut (.clock, .sys_rst, .psel(req.psel), .penable(req.penable),
      .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata, .pready, .pslverr,
      .sarCode, .firstCapSelect, .secondCapGround, .secondCapNegative,
      .samplingSwitchesClosed, .busy, .lowPowerOscEnable, .irq);
   sensor_model sensor (.clock, .firstCapSelect, .samplingSwitchesClosed, .busy, .level0,
      .level1, .calLevel, .sarCode);
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   always @(posedge clock) begin
      if (req.psel && req.penable && !req.pwrite && pready === 1'b1) begin
         note = expQ.pop_front();
         check({pslverr, prdata}, note);
      end
   end
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clock);
      req.penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      req <= '0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
      expQ.push_back({e, d});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic waitLvl(ref logic s, input logic v);
      int i;
      for (i = 0; i < 3000 && s !== v; i++) @(posedge clock);
      if (s !== v) n_mismatch++;
   endtask : waitLvl
   task automatic nextSample;
      repeat (2) begin
         waitLvl(samplingSwitchesClosed, 1'b0);
         waitLvl(samplingSwitchesClosed, 1'b1);
      end
   endtask : nextSample
   function automatic logic [31:0] expRes(input logic [11:0] c, input logic [11:0] o);
      int v;
      v = int'(c) - int'(o) + 'h800;
      return (v < 0) ? 32'h0 : (v > 'hfff) ? 32'hfff : 32'(v);
   endfunction : expRes
   task automatic convert(input logic [11:0] c, input logic [11:0] o);
      level0 <= c;
      repeat (2) begin
         apb(1'b1, `OFS_IRQ_CLEAR, 32'h1);
         repeat (3) @(posedge clock);
         waitLvl(irq, 1'b1);
      end
      rd(`OFS_RESULT, expRes(c, o), 1'b0);
   endtask : convert
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      #1 check(busy, 1);
      waitLvl(busy, 1'b0);
      rd(`OFS_INPUT_CFG, 32'h0, 1'b0);
      rd(`OFS_MODE_CFG, 32'h0, 1'b0);
      rd(`OFS_SEQ_EN, 32'h1, 1'b0);
      rd(`OFS_OSC_CFG, 32'h0, 1'b0);
      rd(`OFS_CONV_CLKS, 32'h20, 1'b0);
      rd(`OFS_OFFSET_VAL, 32'h805, 1'b0);
      rd(12'h030, 32'h0, 1'b1);
      $display("reset and defaults done");
      apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      convert(12'h002, 12'h805);
      convert(12'h900, 12'h805);
      convert(12'hfff, 12'h805);
      convert(lfsr[11:0], 12'h805);
      calLevel <= 12'h7fe;
      apb(1'b1, `OFS_CAL_CTRL, 32'h1);
      waitLvl(busy, 1'b1);
      waitLvl(busy, 1'b0);
      rd(`OFS_OFFSET_VAL, 32'h7fe, 1'b0);
      convert(12'h7f0, 12'h7fe);
      $display("calibration and coding done");
      apb(1'b1, `OFS_SEQ_EN, 32'h2);
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, `OFS_MODE_CFG, 32'(m));
         rd(`OFS_MODE_CFG, 32'(m), 1'b0);
         nextSample();
         check(firstCapSelect, m >= 4);
      end
      $display("modes done");
      apb(1'b1, `OFS_SEQ_EN, 32'h3);
      apb(1'b1, `OFS_MODE_CFG, 32'h4);
      apb(1'b1, `OFS_IRQ_ENABLE, 32'h4);
      for (int a = 0; a < 4; a++) begin
         apb(1'b1, `OFS_INPUT_CFG, 32'(a));
         nextSample();
         check(secondCapGround, a == 0 || a == 3);
         check(secondCapNegative, a == 1 || a == 2);
         check(irq, a == 1);
         apb(1'b1, `OFS_IRQ_CLEAR, 32'h4);
         repeat (3) @(posedge clock);
      end
      apb(1'b1, `OFS_SEQ_EN, 32'h1);
      apb(1'b1, `OFS_INPUT_CFG, 32'h0);
      apb(1'b1, `OFS_MODE_CFG, 32'h0);
      $display("arrangements done");
      apb(1'b1, `OFS_CONV_CLKS, 32'h8);
      for (int o = 0; o < 2; o++) begin
         apb(1'b1, `OFS_OSC_CFG, 32'(o));
         rd(`OFS_OSC_CFG, 32'(o), 1'b0);
         check(lowPowerOscEnable, o);
         nextSample();
         t0 = cycles;
         nextSample();
         check(cycles - t0, o ? 512 : 16);
      end
      $display("oscillator timing done");
      stop_test();
   end
endmodule : tb
`default_nettype wire
